/* bench/cdds_done_status_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module cdds_done_status_monitor (
  input wire logic                           clock,
  input wire logic                           srst,
  input wire logic [cdds_pkg::ADDR_W-1:0]    regAddr,
  input wire logic [cdds_pkg::DATA_W-1:0]    regWdata,
  input wire logic                           regWrite,
  input wire logic                           regRead,
  input wire logic [cdds_pkg::DATA_W-1:0]    regRdata,
  input wire logic [cdds_pkg::NUM_FLAGS-1:0] lastIssued,
  input wire logic [cdds_pkg::NUM_FLAGS-1:0] doneFlags,
  input wire logic                           dmaEventIrq0,
  input wire logic                           port2ASrc3Done,
  input wire logic                           port1AncBSrc10Done
);
  import cdds_pkg::*;
  logic [NUM_FLAGS-1:0] enable_q;
  logic [NUM_FLAGS-1:0] clear_q;
  logic [NUM_FLAGS-1:0] pending_q;
  wire logic            wrStat = regWrite && regAddr == STATUS_OFFSET;
  wire logic            mapped = regAddr inside {STATUS_OFFSET,
    ENABLE_OFFSET, PENDING_OFFSET, OVERRUN_OFFSET, EVCOUNT_OFFSET};
  // pending only tracks issue-to-flag; reissue while set is not followed
  always_ff @(posedge clock) begin
    if (srst) begin
      enable_q <= '0;
      clear_q <= '0;
      pending_q <= '0;
    end else begin
      if (regWrite && regAddr == ENABLE_OFFSET)
        enable_q <= regWdata[NUM_FLAGS-1:0];
      clear_q <= wrStat ? regWdata[NUM_FLAGS-1:0] : '0;
      pending_q <= (pending_q | lastIssued) & ~doneFlags;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_reset_clear;
    disable iff (1'b0) srst |=> doneFlags == '0 && !dmaEventIrq0;
  endproperty
  property p_sticky;
    (($past(doneFlags) & ~doneFlags) & ~clear_q) == '0;
  endproperty
  property p_set_cause;
    (doneFlags & ~$past(doneFlags) & ~pending_q) == '0;
  endproperty
  property p_latency;
    lastIssued[0] && !doneFlags[0] |=> !doneFlags[0];
  endproperty
  property p_irq;
    dmaEventIrq0 == |(doneFlags & enable_q);
  endproperty
  property p_rd_idle;
    $past(regRead) == 1'b0 |-> regRdata == '0;
  endproperty
  property p_rd_status;
    regRead && regAddr == STATUS_OFFSET |=>
      regRdata == {16'h0000, $past(doneFlags)};
  endproperty
  property p_rd_enable;
    regRead && regAddr == ENABLE_OFFSET |=>
      regRdata == {16'h0000, $past(enable_q)};
  endproperty
  property p_rd_unmapped;
    regRead && !mapped |=> regRdata == '0;
  endproperty
  property p_copy;
    port2ASrc3Done == doneFlags[15] && port1AncBSrc10Done == doneFlags[0];
  endproperty
  // a cleared bit may only survive if its completion was still in flight
  property p_clear;
    ((doneFlags & clear_q) & ~pending_q) == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("flags not cleared by reset");
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");
  a_set_cause: assert property (p_set_cause)
    else $error("flag set without last transfer");
  a_latency: assert property (p_latency)
    else $error("flag set too early");
  a_irq: assert property (p_irq)
    else $error("interrupt mismatch");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  a_rd_status: assert property (p_rd_status)
    else $error("status read mismatch");
  a_rd_enable: assert property (p_rd_enable)
    else $error("enable read mismatch");
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  a_copy: assert property (p_copy)
    else $error("named flag copy mismatch");
  a_clear: assert property (p_clear)
    else $error("flag not cleared by write of one");
  c_irq: cover property ($rose(dmaEventIrq0));
  c_clear: cover property (wrStat && |regWdata[NUM_FLAGS-1:0]);
  c_top: cover property ($rose(doneFlags[15]));
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
  end \
end
module testbench;
  import cdds_pkg::*;
  logic                   clock = 1'b0;
  logic                   srst = 1'b1;
  logic [ADDR_W-1:0]      regAddr = '0;
  logic [DATA_W-1:0]      regWdata = '0;
  logic                   regWrite = 1'b0;
  logic                   regRead = 1'b0;
  logic [DATA_W-1:0]      regRdata;
  logic [NUM_FLAGS-1:0]   beatSent = '0;
  logic [NUM_FLAGS-1:0]   beatAccepted = '0;
  logic [NUM_FLAGS-1:0]   lastIssued = '0;
  logic [NUM_CLIENTS-1:0] clientPush = '0;
  logic [NUM_CLIENTS-1:0] clientPop = '0;
  logic [NUM_CLIENTS-1:0] newChannelSetup = '0;
  logic [NUM_FLAGS-1:0]   doneFlags;
  logic [NUM_FLAGS-1:0]   named;
  logic [NUM_FLAGS-1:0]   expF;
  logic [NUM_FLAGS-1:0]   m;
  logic                   dmaEventIrq0;
  logic                   rdPend = 1'b0;
  logic [DATA_W-1:0]      expRd;
  logic [DATA_W-1:0]      expQ[$];
  int                     failures = 0;
  int                     checks_done = 0;
  cdds_done_status i_dut (.*,
    .port2ASrc3Done(named[15]), .port2ASrc2Done(named[14]),
    .port2ASrc1Done(named[13]), .port2ASrc0Done(named[12]),
    .port1BRgbDone(named[11]), .port1ARgbDone(named[10]),
    .port1BChromaDone(named[9]), .port1BLumaDone(named[8]),
    .port1AChromaDone(named[7]), .port1ALumaDone(named[6]),
    .port1AncBSrc15Done(named[5]), .port1AncBSrc14Done(named[4]),
    .port1AncBSrc13Done(named[3]), .port1AncBSrc12Done(named[2]),
    .port1AncBSrc11Done(named[1]), .port1AncBSrc10Done(named[0]));
  always #25 clock = ~clock;
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge clock);
    regRead <= 1'b0;
  endtask
  task automatic ev(input logic [NUM_FLAGS-1:0] li, bs, ba);
    @(posedge clock);
    lastIssued <= li;
    beatSent <= bs;
    beatAccepted <= ba;
    @(posedge clock);
    lastIssued <= '0;
    beatSent <= '0;
    beatAccepted <= '0;
  endtask
  task automatic cl(input logic [NUM_CLIENTS-1:0] pu, po);
    @(posedge clock);
    clientPush <= pu;
    clientPop <= po;
    @(posedge clock);
    clientPush <= '0;
    clientPop <= '0;
  endtask
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // read data is only valid in the slot after the strobe
  always @(posedge clock) begin
    if (rdPend) begin
      expRd = expQ.pop_front();
      `CHK(regRdata, expRd)
    end
    rdPend <= regRead;
  end
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
  initial begin
    void'($urandom(10));
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    idle(1);
    `CHK(doneFlags, 16'h0000)
    rd(STATUS_OFFSET, 32'h0);
    rd(ENABLE_OFFSET, 32'h0);
    rd(8'h70, 32'h0);
    expF = '0;
    repeat (4) begin
      m = 16'($urandom);
      ev(m, '0, '0);
      idle(3);
      expF |= m;
      `CHK(doneFlags, expF)
    end
    for (int i = 0; i < 16; i++) begin
      ev(16'h0001 << i, '0, '0);
      idle(3);
      expF[i] = 1'b1;
      `CHK(named, expF)
    end
    wr(STATUS_OFFSET, 32'h0);
    idle(1);
    `CHK(doneFlags, 16'hffff)
    m = 16'($urandom);
    wr(STATUS_OFFSET, {16'hffff, m});
    rd(STATUS_OFFSET, {16'h0, ~m});
    wr(STATUS_OFFSET, 32'hffff);
    wr(ENABLE_OFFSET, 32'h0001);
    ev(16'h0002, '0, '0);
    idle(3);
    `CHK(dmaEventIrq0, 1'b0)
    ev(16'h0001, '0, '0);
    idle(3);
    `CHK(dmaEventIrq0, 1'b1)
    rd(PENDING_OFFSET, 32'h0001);
    rd(ENABLE_OFFSET, 32'h0001);
    wr(ENABLE_OFFSET, 32'h0);
    idle(1);
    `CHK(dmaEventIrq0, 1'b0)
    wr(ENABLE_OFFSET, 32'h0003);
    wr(STATUS_OFFSET, 32'h0001);
    idle(1);
    `CHK(dmaEventIrq0, 1'b1)
    wr(STATUS_OFFSET, 32'h0002);
    idle(1);
    `CHK(dmaEventIrq0, 1'b0)
    repeat (3) ev('0, 16'h0004, '0);
    ev(16'h0004, '0, '0);
    idle(5);
    `CHK(doneFlags[2], 1'b0)
    repeat (3) ev('0, '0, 16'h0004);
    idle(4);
    `CHK(doneFlags[2], 1'b1)
    cl(4'h8, 4'h0);
    ev(16'h0001, '0, '0);
    idle(5);
    `CHK(doneFlags[0], 1'b0)
    cl(4'h0, 4'h8);
    idle(4);
    `CHK(doneFlags[0], 1'b1)
    @(posedge clock);
    newChannelSetup <= 4'h2;
    cl(4'h2, 4'h0);
    ev(16'h0800, '0, '0);
    idle(4);
    `CHK(doneFlags[11], 1'b1)
    cl(4'h0, 4'h2);
    newChannelSetup <= 4'h0;
    // event and clearing write meet at the same edge
    ev(16'h0008, '0, '0);
    wr(STATUS_OFFSET, 32'h0008);
    idle(1);
    `CHK(doneFlags[3], 1'b1)
    @(posedge clock);
    srst <= 1'b1;
    idle(3);
    `CHK(doneFlags, 16'h0000)
    `CHK(dmaEventIrq0, 1'b0)
    @(posedge clock);
    srst <= 1'b0;
    rd(ENABLE_OFFSET, 32'h0);
    // second completion on a standing flag is an overrun, both are counted
    repeat (2) begin
      ev(16'h0010, '0, '0);
      idle(3);
    end
    `CHK(doneFlags, 16'h0010)
    rd(OVERRUN_OFFSET, 32'h0010);
    rd(EVCOUNT_OFFSET, 32'h0002);
    wr(EVCOUNT_OFFSET, 32'h0);
    wr(OVERRUN_OFFSET, 32'h0010);
    rd(EVCOUNT_OFFSET, 32'h0);
    rd(OVERRUN_OFFSET, 32'h0);
    idle(2);
    end_of_test();
  end
endmodule
bind cdds_done_status cdds_done_status_monitor i_mon (.*);
`default_nettype wire

/* design/cdds_client_drain.sv */
`timescale 1ns/10ps
`default_nettype none
module cdds_client_drain #(
  parameter int unsigned NC = cdds_pkg::NUM_CLIENTS,
  parameter int unsigned N  = cdds_pkg::NUM_FLAGS,
  parameter int unsigned OW = cdds_pkg::OCC_W
) (
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic [NC-1:0] clientPush,
  input  wire logic [NC-1:0] clientPop,
  input  wire logic [NC-1:0] newChannelSetup,
  cdds_evt_if.drain          evt
);
  import cdds_pkg::*;

  typedef struct packed {
    logic [NC-1:0][OW-1:0] occ;
  } cdds_drain_s;

  cdds_drain_s     q;
  cdds_drain_s     d;
  logic [N-1:0]    ready;

  always_comb begin
    d = q;
    for (int c = 0; c < NC; c++) begin
      d.occ[c] = q.occ[c] + {{(OW-1){1'b0}}, clientPush[c]}
                          - {{(OW-1){1'b0}}, clientPop[c]};
    end
    if (srst) begin
      d = '0;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  // flags without a client never wait; a new channel lets data stay queued
  always_comb begin
    ready = '1;
    for (int c = 0; c < NC; c++) begin
      if (q.occ[c] != '0 && !newChannelSetup[c]) begin
        ready = ready & ~CLIENT_MASK[c];
      end
    end
  end

  assign evt.clientReady = ready;
endmodule
`default_nettype wire

/* design/cdds_done_status.sv */
// Contract
// - A flag sets only after the last write of its channel is done and memory accepted every beat.
// - A set flag stays at one whatever the hardware does until software clears it.
// - Writing a one into a flag position clears that flag; a completion in the same cycle keeps it set.
// - All flags in bits 15 to 0 are zero after reset.
// - Bits 15 to 12 report port 2 port A sources 3, 2, 1 and 0.
// - Bit 11 reports port 1 port B RGB and bit 10 port 1 port A RGB.
// - Bits 9 to 6 report port 1 B chroma, B luma, A chroma and A luma.
// - Bits 5 to 0 report port 1 ancillary B sources 15 down to 10.
// - When a flag sets with no new channel set up, its write client holds no data.
// - An event reaches the interrupt only when its enable bit is one.
`timescale 1ns/10ps
`default_nettype none
module cdds_done_status #(
  parameter int unsigned NF  = cdds_pkg::NUM_FLAGS,
  parameter int unsigned NC  = cdds_pkg::NUM_CLIENTS,
  parameter int unsigned BCW = cdds_pkg::BEAT_CNT_W,
  parameter int unsigned OCW = cdds_pkg::OCC_W
) (
  input  wire logic                         clock,
  input  wire logic                         srst,
  input  wire logic [cdds_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [cdds_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                         regWrite,
  input  wire logic                         regRead,
  output logic      [cdds_pkg::DATA_W-1:0]  regRdata,
  input  wire logic [NF-1:0]                beatSent,
  input  wire logic [NF-1:0]                beatAccepted,
  input  wire logic [NF-1:0]                lastIssued,
  input  wire logic [NC-1:0]                clientPush,
  input  wire logic [NC-1:0]                clientPop,
  input  wire logic [NC-1:0]                newChannelSetup,
  output logic      [NF-1:0]                doneFlags,
  output logic                              dmaEventIrq0,
  output logic                              port2ASrc3Done,
  output logic                              port2ASrc2Done,
  output logic                              port2ASrc1Done,
  output logic                              port2ASrc0Done,
  output logic                              port1BRgbDone,
  output logic                              port1ARgbDone,
  output logic                              port1BChromaDone,
  output logic                              port1BLumaDone,
  output logic                              port1AChromaDone,
  output logic                              port1ALumaDone,
  output logic                              port1AncBSrc15Done,
  output logic                              port1AncBSrc14Done,
  output logic                              port1AncBSrc13Done,
  output logic                              port1AncBSrc12Done,
  output logic                              port1AncBSrc11Done,
  output logic                              port1AncBSrc10Done
);
  import cdds_pkg::*;

  localparam int unsigned PAD_W  = DATA_W - NF;
  localparam int unsigned CPAD_W = DATA_W - EVCNT_W;

  typedef struct packed {
    logic [NF-1:0]      status;
    logic [NF-1:0]      enable;
    logic [NF-1:0]      overrun;
    logic [EVCNT_W-1:0] evCount;
    logic [DATA_W-1:0]  rdata;
    logic               irq;
  } cdds_status_s;

  cdds_status_s q;
  cdds_status_s d;

  logic               wrStatus;
  logic               wrEnable;
  logic               wrOverrun;
  logic               wrEvCount;
  logic [NF-1:0]      statusClr;
  logic [NF-1:0]      overrunClr;
  logic [NF-1:0]      newEvents;
  logic [EVCNT_W-1:0] eventSum;

  cdds_evt_if #(.N(NF)) evt ();

  cdds_done_tracker #(
    .N  (NF),
    .CW (BCW)
  ) u_tracker (
    .clock        (clock),
    .srst         (srst),
    .beatSent     (beatSent),
    .beatAccepted (beatAccepted),
    .lastIssued   (lastIssued),
    .evt          (evt.tracker)
  );

  cdds_client_drain #(
    .NC (NC),
    .N  (NF),
    .OW (OCW)
  ) u_drain (
    .clock           (clock),
    .srst            (srst),
    .clientPush      (clientPush),
    .clientPop       (clientPop),
    .newChannelSetup (newChannelSetup),
    .evt             (evt.drain)
  );

  assign newEvents = evt.doneEvent;

  // write decode; a strobe touches one register only
  always_comb begin
    wrStatus  = 1'b0;
    wrEnable  = 1'b0;
    wrOverrun = 1'b0;
    wrEvCount = 1'b0;
    if (regWrite && regAddr == STATUS_OFFSET) begin
      wrStatus = 1'b1;
    end else if (regWrite && regAddr == ENABLE_OFFSET) begin
      wrEnable = 1'b1;
    end else if (regWrite && regAddr == OVERRUN_OFFSET) begin
      wrOverrun = 1'b1;
    end else if (regWrite && regAddr == EVCOUNT_OFFSET) begin
      wrEvCount = 1'b1;
    end
  end

  // only the ones in the write data clear; zeros leave flags untouched
  assign statusClr  = wrStatus ? regWdata[NF-1:0] : '0;
  assign overrunClr = wrOverrun ? regWdata[NF-1:0] : '0;

  // number of flags set in this cycle, for the running event count
  always_comb begin
    eventSum = '0;
    for (int i = 0; i < NF; i++) begin
      eventSum = eventSum + {{(EVCNT_W-1){1'b0}}, newEvents[i]};
    end
  end

  always_comb begin
    d = q;

    // set is or-ed in after the clear, so a same-cycle event survives
    d.status = (q.status & ~statusClr) | newEvents;

    // a completion that finds its flag still standing means software
    // fell behind; the flag itself cannot count it, so note it here
    d.overrun = (q.overrun & ~overrunClr)
              | (newEvents & q.status & ~statusClr);

    if (wrEnable) begin
      d.enable = regWdata[NF-1:0];
    end

    // wraps rather than saturates; software reads differences
    if (wrEvCount) begin
      d.evCount = eventSum;
    end else begin
      d.evCount = q.evCount + eventSum;
    end

    // registered from the next flags so the line tracks them exactly
    d.irq = |(d.status & d.enable);

    // read data valid for one cycle only, zero otherwise
    d.rdata = '0;
    if (regRead) begin
      if (regAddr == STATUS_OFFSET) begin
        d.rdata = {{PAD_W{1'b0}}, q.status};
      end else if (regAddr == ENABLE_OFFSET) begin
        d.rdata = {{PAD_W{1'b0}}, q.enable};
      end else if (regAddr == PENDING_OFFSET) begin
        d.rdata = {{PAD_W{1'b0}}, q.status & q.enable};
      end else if (regAddr == OVERRUN_OFFSET) begin
        d.rdata = {{PAD_W{1'b0}}, q.overrun};
      end else if (regAddr == EVCOUNT_OFFSET) begin
        d.rdata = {{CPAD_W{1'b0}}, q.evCount};
      end else begin
        d.rdata = '0;
      end
    end

    if (srst) begin
      d.status  = STATUS_RESET;
      d.enable  = ENABLE_RESET;
      d.overrun = OVERRUN_RESET;
      d.evCount = EVCOUNT_RESET;
      d.rdata   = '0;
      d.irq     = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign regRdata     = q.rdata;
  assign dmaEventIrq0 = q.irq;
  assign doneFlags    = q.status;

  // named views of the flag bits
  assign port2ASrc3Done     = q.status[BIT_PORT2_A_SRC3];
  assign port2ASrc2Done     = q.status[BIT_PORT2_A_SRC2];
  assign port2ASrc1Done     = q.status[BIT_PORT2_A_SRC1];
  assign port2ASrc0Done     = q.status[BIT_PORT2_A_SRC0];
  assign port1BRgbDone      = q.status[BIT_PORT1_B_RGB];
  assign port1ARgbDone      = q.status[BIT_PORT1_A_RGB];
  assign port1BChromaDone   = q.status[BIT_PORT1_B_CHROMA];
  assign port1BLumaDone     = q.status[BIT_PORT1_B_LUMA];
  assign port1AChromaDone   = q.status[BIT_PORT1_A_CHROMA];
  assign port1ALumaDone     = q.status[BIT_PORT1_A_LUMA];
  assign port1AncBSrc15Done = q.status[BIT_PORT1_ANCB_SRC15];
  assign port1AncBSrc14Done = q.status[BIT_PORT1_ANCB_SRC14];
  assign port1AncBSrc13Done = q.status[BIT_PORT1_ANCB_SRC13];
  assign port1AncBSrc12Done = q.status[BIT_PORT1_ANCB_SRC12];
  assign port1AncBSrc11Done = q.status[BIT_PORT1_ANCB_SRC11];
  assign port1AncBSrc10Done = q.status[BIT_PORT1_ANCB_SRC10];
endmodule
`default_nettype wire

/* design/cdds_done_tracker.sv */
`timescale 1ns/10ps
`default_nettype none
module cdds_done_tracker #(
  parameter int unsigned N  = cdds_pkg::NUM_FLAGS,
  parameter int unsigned CW = cdds_pkg::BEAT_CNT_W
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [N-1:0] beatSent,
  input  wire logic [N-1:0] beatAccepted,
  input  wire logic [N-1:0] lastIssued,
  cdds_evt_if.tracker       evt
);
  import cdds_pkg::*;

  typedef struct packed {
    cdds_trk_e [N-1:0]         state;
    logic      [N-1:0][CW-1:0] cnt;
    logic      [N-1:0]         done;
  } cdds_trk_s;

  cdds_trk_s q;
  cdds_trk_s d;

  always_comb begin
    d = q;
    for (int i = 0; i < N; i++) begin
      // beats in flight: sent but not yet accepted by memory
      d.cnt[i] = q.cnt[i] + {{(CW-1){1'b0}}, beatSent[i]}
                          - {{(CW-1){1'b0}}, beatAccepted[i]};
      d.done[i] = 1'b0;
      case (q.state[i])
        CDDS_TRK_IDLE: begin
          if (lastIssued[i]) begin
            d.state[i] = CDDS_TRK_WAIT;
          end
        end
        CDDS_TRK_WAIT: begin
          // no beat may still be on its way, and the client must be drained unless a new channel is set up on it
          if (q.cnt[i] == '0 && !beatSent[i] && evt.clientReady[i]) begin
            d.done[i]  = 1'b1;
            d.state[i] = CDDS_TRK_IDLE;
          end
        end
        default: begin
          d.state[i] = CDDS_TRK_IDLE;
        end
      endcase
    end
    if (srst) begin
      d = '0;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign evt.doneEvent = q.done;
endmodule
`default_nettype wire

/* include/cdds_evt_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cdds_evt_if #(
  parameter int unsigned N = cdds_pkg::NUM_FLAGS
);
  logic [N-1:0] doneEvent;
  logic [N-1:0] clientReady;

  modport tracker (input clientReady, output doneEvent);
  modport drain   (output clientReady);
  modport status  (input doneEvent);
endinterface
`default_nettype wire

/* include/cdds_pkg.sv */
`default_nettype none
package cdds_pkg;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned NUM_FLAGS    = 16;
  localparam int unsigned NUM_CLIENTS  = 4;
  localparam int unsigned BEAT_CNT_W   = 8;
  localparam int unsigned OCC_W        = 10;
  localparam int unsigned EVCNT_W      = 16;

  localparam logic [ADDR_W-1:0] STATUS_OFFSET  = 8'h58;
  localparam logic [ADDR_W-1:0] ENABLE_OFFSET  = 8'h5c;
  localparam logic [ADDR_W-1:0] PENDING_OFFSET = 8'h60;
  localparam logic [ADDR_W-1:0] OVERRUN_OFFSET = 8'h64;
  localparam logic [ADDR_W-1:0] EVCOUNT_OFFSET = 8'h68;

  localparam logic [NUM_FLAGS-1:0] STATUS_RESET  = 16'h0000;
  localparam logic [NUM_FLAGS-1:0] ENABLE_RESET  = 16'h0000;
  localparam logic [NUM_FLAGS-1:0] OVERRUN_RESET = 16'h0000;
  localparam logic [EVCNT_W-1:0]   EVCOUNT_RESET = 16'h0000;

  localparam int unsigned BIT_PORT2_A_SRC3    = 15;
  localparam int unsigned BIT_PORT2_A_SRC2    = 14;
  localparam int unsigned BIT_PORT2_A_SRC1    = 13;
  localparam int unsigned BIT_PORT2_A_SRC0    = 12;
  localparam int unsigned BIT_PORT1_B_RGB     = 11;
  localparam int unsigned BIT_PORT1_A_RGB     = 10;
  localparam int unsigned BIT_PORT1_B_CHROMA  = 9;
  localparam int unsigned BIT_PORT1_B_LUMA    = 8;
  localparam int unsigned BIT_PORT1_A_CHROMA  = 7;
  localparam int unsigned BIT_PORT1_A_LUMA    = 6;
  localparam int unsigned BIT_PORT1_ANCB_SRC15 = 5;
  localparam int unsigned BIT_PORT1_ANCB_SRC14 = 4;
  localparam int unsigned BIT_PORT1_ANCB_SRC13 = 3;
  localparam int unsigned BIT_PORT1_ANCB_SRC12 = 2;
  localparam int unsigned BIT_PORT1_ANCB_SRC11 = 1;
  localparam int unsigned BIT_PORT1_ANCB_SRC10 = 0;

  // client order: port2 lower luma, port1 lower luma, port1 upper, anc b
  localparam logic [NUM_FLAGS-1:0] CLIENT_MASK [NUM_CLIENTS] = '{
    16'hf000, 16'h0800, 16'h0400, 16'h003f
  };

  typedef enum logic {CDDS_TRK_IDLE, CDDS_TRK_WAIT} cdds_trk_e;
endpackage
`default_nettype wire
